// ### rtl/spi_eeprom_map.svh
/*
  Constants of the serial EEPROM port: pin order, opcodes, status bit
  positions, bus offsets, reset values and timing.
  Assumes it is included by bare name from the design files.
*/
`ifndef SPI_EEPROM_MAP_SVH
`define SPI_EEPROM_MAP_SVH

// ****************************************
// Pin vector positions and idle levels
// ****************************************
`define EE_PIN_CS 4
`define EE_PIN_SCK 3
`define EE_PIN_SI 2
`define EE_PIN_HOLD 1
`define EE_PIN_WP 0
`define EE_PIN_RST 5'h13

// ****************************************
// Opcodes
// ****************************************
`define EE_OP_READ 8'h03
`define EE_OP_WRITE 8'h02
`define EE_OP_LATCH_SET 8'h06
`define EE_OP_LATCH_CLR 8'h04
`define EE_OP_STAT_RD 8'h05
`define EE_OP_STAT_WR 8'h01

// ****************************************
// Status byte bit positions
// ****************************************
`define EE_ST_BUSY 0
`define EE_ST_LATCH 1
`define EE_ST_GUARD_LO 2
`define EE_ST_GUARD_HI 3
`define EE_ST_PEN 7

// ****************************************
// Field lengths, counted from zero
// ****************************************
`define EE_BYTE_LAST 5'd7
`define EE_ADDR_LAST 5'd15

// ****************************************
// Bus register offsets and reset values
// ****************************************
`define EE_REG_STATUS 8'h00
`define EE_REG_CONFIG 8'h04
`define EE_REG_PEEK_ADDR 8'h08
`define EE_REG_PEEK_DATA 8'h0C
`define EE_CFG_GUARD_RST 1'b1
`define EE_NV_RST 3'h0

// ****************************************
// Timing
// ****************************************
`define EE_TWC_NS 5000000
`define EE_CLK_NS 5

`endif

// ### rtl/spi_eeprom_pkg.sv
/*
  Types of the serial EEPROM port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spi_eeprom_pkg;

  // ****************************************
  // Serial sequence states
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_CMD = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_RDATA = 4'b0011,
    ST_WDATA = 4'b0100,
    ST_SRD = 4'b0101,
    ST_SWR = 4'b0110,
    ST_ARMED = 4'b0111,
    ST_IGNORE = 4'b1000
  } seq_state_e;

endpackage

// ### rtl/spi_eeprom_port.sv
/*
  Serial EEPROM port: 2048 x 8 array behind a serial link with select,
  pause and write-protect pins, plus an APB window for test and status.
  Assumes the link pins are asynchronous to i_clk and much slower than it;
  the testbench resolves the shared data-out wire from o_so_oe.
*/
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "spi_eeprom_map.svh"

module spi_eeprom_port #(
  parameter int unsigned WRITE_CYCLES = `EE_TWC_NS / `EE_CLK_NS
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  output logic o_so,
  output logic o_so_oe,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  import spi_eeprom_pkg::*;

  localparam logic [19:0] TWC = WRITE_CYCLES[19:0];

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [4:0] pin_raw;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] sync3_q;
  logic [4:0] pin_q;
  logic [4:0] pin_prev_q;
  logic [4:0] pin_diff;

  assign pin_raw = {i_cs_n, i_sck, i_si, i_hold_n, i_wp_n};
  assign pin_diff = sync2_q ^ sync3_q;

  // Three stages; a level counts only once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync1_q <= `EE_PIN_RST;
      sync2_q <= `EE_PIN_RST;
      sync3_q <= `EE_PIN_RST;
      pin_q <= `EE_PIN_RST;
      pin_prev_q <= `EE_PIN_RST;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q <= (sync2_q & ~pin_diff) | (pin_q & pin_diff);
      pin_prev_q <= pin_q;
    end
  end

  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic wp_n;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic hold_fall;
  logic hold_rise;

  assign cs_n = pin_q[`EE_PIN_CS];
  assign sck = pin_q[`EE_PIN_SCK];
  assign si = pin_q[`EE_PIN_SI];
  assign hold_n = pin_q[`EE_PIN_HOLD];
  assign wp_n = pin_q[`EE_PIN_WP];
  assign cs_fall = pin_prev_q[`EE_PIN_CS] & ~cs_n;
  assign cs_rise = ~pin_prev_q[`EE_PIN_CS] & cs_n;
  assign sck_rise = ~pin_prev_q[`EE_PIN_SCK] & sck;
  assign sck_fall = pin_prev_q[`EE_PIN_SCK] & ~sck;
  assign hold_fall = pin_prev_q[`EE_PIN_HOLD] & ~hold_n;
  assign hold_rise = ~pin_prev_q[`EE_PIN_HOLD] & hold_n;

  // ****************************************
  // Power-up select and pause control
  // ****************************************
  logic seen_low_q;
  logic paused_q;
  logic pause_pend_q;

  // A sequence may only open after select was seen low once
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      seen_low_q <= 1'b0;
    end else if (!cs_n) begin
      seen_low_q <= 1'b1;
    end
  end

  // Pause waits for clock low; a release with clock high is not honoured
  always_ff @(posedge i_clk) begin
    if (i_srst || cs_n) begin
      paused_q <= 1'b0;
      pause_pend_q <= 1'b0;
    end else if (hold_fall) begin
      paused_q <= paused_q | ~sck;
      pause_pend_q <= sck;
    end else if (hold_rise) begin
      pause_pend_q <= 1'b0;
      if (!sck) begin
        paused_q <= 1'b0;
      end
    end else if (pause_pend_q && sck_fall) begin
      paused_q <= 1'b1;
      pause_pend_q <= 1'b0;
    end
  end

  logic rise_ev;
  logic fall_ev;

  // Clock edges are dead while paused, so sequence state is frozen
  assign rise_ev = ~cs_n & ~paused_q & sck_rise;
  assign fall_ev = ~cs_n & ~paused_q & sck_fall;

  // ****************************************
  // Storage and status
  // ****************************************
  logic [7:0] mem_q [0:2047];
  logic [7:0] pbuf_q [0:15];
  logic [15:0] pmask_q;
  logic latch_q;
  logic busy_q;
  logic pen_q;
  logic [1:0] guard_q;
  logic guard_en_q;
  logic [7:0] status;

  // Status byte; unused bits read zero
  always_comb begin
    status = 8'h00;
    status[`EE_ST_BUSY] = busy_q;
    status[`EE_ST_LATCH] = latch_q;
    status[`EE_ST_GUARD_LO] = guard_q[0];
    status[`EE_ST_GUARD_HI] = guard_q[1];
    status[`EE_ST_PEN] = pen_q;
  end

  // Block guard map, honoured only when the bus enables it
  function automatic logic guard_hit(input logic [1:0] g, input logic [10:0] a);
    guard_hit = (g == 2'b11) | ((g == 2'b10) & a[10]) | ((g == 2'b01) & (&a[10:9]));
  endfunction

  // ****************************************
  // Serial sequence
  // ****************************************
  seq_state_e st_q;
  logic [4:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] op_q;
  logic [10:0] addr_q;
  logic [7:0] out_q;
  logic [2:0] nv_q;
  logic [7:0] sh_nx;
  logic [10:0] addr_nx;
  logic [10:0] addr_ld;
  logic byte_end;
  logic addr_end;

  assign sh_nx = {sh_q[6:0], si};
  assign addr_nx = addr_q + 11'd1;
  assign addr_ld = {addr_q[9:0], si};
  assign byte_end = rise_ev & (cnt_q == `EE_BYTE_LAST);
  assign addr_end = rise_ev & (st_q == ST_ADDR) & (cnt_q == `EE_ADDR_LAST);

  // Shifts fields in MSB first and walks the command through its phases
  always_ff @(posedge i_clk) begin
    if (i_srst || cs_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 5'd0;
      sh_q <= 8'h00;
      op_q <= 8'h00;
      out_q <= 8'h00;
      if (i_srst) begin
        addr_q <= 11'h000;
        nv_q <= `EE_NV_RST;
      end
    end else if (cs_fall) begin
      st_q <= seen_low_q ? ST_CMD : ST_IDLE;
      cnt_q <= 5'd0;
    end else if (rise_ev) begin
      cnt_q <= cnt_q + 5'd1;
      sh_q <= sh_nx;
      case (st_q)
        ST_CMD: begin
          if (byte_end) begin
            cnt_q <= 5'd0;
            op_q <= sh_nx;
            case (sh_nx)
              `EE_OP_READ, `EE_OP_WRITE: st_q <= ST_ADDR;
              `EE_OP_LATCH_SET, `EE_OP_LATCH_CLR: st_q <= ST_ARMED;
              `EE_OP_STAT_RD: begin
                st_q <= ST_SRD;
                out_q <= status;
              end
              `EE_OP_STAT_WR: st_q <= ST_SWR;
              default: st_q <= ST_IGNORE;
            endcase
          end
        end
        ST_ADDR: begin
          addr_q <= addr_ld;
          if (addr_end) begin
            cnt_q <= 5'd0;
            if (busy_q) begin
              st_q <= ST_IGNORE;
            end else if (op_q == `EE_OP_READ) begin
              st_q <= ST_RDATA;
              out_q <= mem_q[addr_ld];
            end else begin
              st_q <= ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (byte_end) begin
            cnt_q <= 5'd0;
            addr_q <= addr_nx;
            out_q <= mem_q[addr_nx];
          end
        end
        ST_WDATA: begin
          if (byte_end) begin
            cnt_q <= 5'd0;
            addr_q[3:0] <= addr_q[3:0] + 4'd1;
          end
        end
        ST_SRD: begin
          if (byte_end) begin
            cnt_q <= 5'd0;
            out_q <= status;
          end
        end
        ST_SWR: begin
          if (byte_end) begin
            cnt_q <= 5'd0;
            st_q <= ST_ARMED;
            nv_q <= {sh_nx[`EE_ST_PEN], sh_nx[`EE_ST_GUARD_HI], sh_nx[`EE_ST_GUARD_LO]};
          end
        end
        ST_ARMED: st_q <= ST_IGNORE;
        default: st_q <= st_q;
      endcase
    end else if (fall_ev) begin
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  // ****************************************
  // Serial output
  // ****************************************
  logic out_state;
  assign out_state = (st_q == ST_RDATA) | (st_q == ST_SRD);

  // Data changes only after a falling clock edge
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_so <= 1'b0;
    end else if (fall_ev) begin
      o_so <= out_q[7];
    end
  end

  // Released whenever deselected, pausing or paused
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_so_oe <= 1'b0;
    end else begin
      o_so_oe <= ~cs_n & hold_n & ~paused_q & out_state;
    end
  end

  // ****************************************
  // Page buffer
  // ****************************************
  // Refilled only by a write accepted while idle, so it is stable in programming
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pmask_q <= 16'h0000;
    end else if (addr_end && op_q == `EE_OP_WRITE && !busy_q) begin
      pmask_q <= 16'h0000;
    end else if (byte_end && st_q == ST_WDATA) begin
      pbuf_q[addr_q[3:0]] <= sh_nx;
      pmask_q[addr_q[3:0]] <= 1'b1;
    end
  end

  // ****************************************
  // Programming cycle and write latch
  // ****************************************
  logic write_go;
  logic stat_go;
  logic prog_done;
  logic stat_kind_q;
  logic [19:0] tmr_q;
  logic [6:0] wpage_q;

  assign write_go = cs_rise & (st_q == ST_WDATA) & (cnt_q == 5'd0) & (|pmask_q)
                    & latch_q & ~busy_q;
  assign stat_go = cs_rise & (st_q == ST_ARMED) & (op_q == `EE_OP_STAT_WR)
                   & latch_q & ~busy_q & ~(pen_q & ~wp_n);
  assign prog_done = busy_q & (tmr_q == 20'd1);

  // Timer ignores select and the protect pin once started
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      busy_q <= 1'b0;
      tmr_q <= 20'd0;
      stat_kind_q <= 1'b0;
      wpage_q <= 7'd0;
    end else if (write_go || stat_go) begin
      busy_q <= 1'b1;
      tmr_q <= TWC;
      stat_kind_q <= stat_go;
      wpage_q <= addr_q[10:4];
    end else if (busy_q) begin
      tmr_q <= tmr_q - 20'd1;
      if (prog_done) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Nonvolatile status bits commit at the end of programming
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pen_q <= 1'(`EE_NV_RST >> 2); // Top bit of the stored triple
      guard_q <= 2'(`EE_NV_RST);
    end else if (prog_done && stat_kind_q) begin
      pen_q <= nv_q[2];
      guard_q <= nv_q[1:0];
    end
  end

  // Array has no reset: it stands for nonvolatile contents
  always_ff @(posedge i_clk) begin
    if (prog_done && !stat_kind_q) begin
      for (int i = 0; i < 16; i++) begin
        if (pmask_q[i] && !(guard_en_q && guard_hit(guard_q, {wpage_q, 4'(i)}))) begin
          mem_q[{wpage_q, 4'(i)}] <= pbuf_q[i];
        end
      end
    end
  end

  logic latch_set;
  logic latch_clr;
  assign latch_set = cs_rise & (st_q == ST_ARMED) & (op_q == `EE_OP_LATCH_SET);
  assign latch_clr = cs_rise & (st_q == ST_ARMED) & (op_q == `EE_OP_LATCH_CLR);

  // Set after a full opcode wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      latch_q <= 1'b0;
    end else if (latch_set) begin
      latch_q <= 1'b1;
    end else if (latch_clr || prog_done) begin
      latch_q <= 1'b0;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic [10:0] peek_q;
  logic apb_acc;
  logic apb_hit;

  assign apb_acc = i_psel & i_penable & ~o_pready;
  assign apb_hit = (i_paddr == `EE_REG_STATUS) | (i_paddr == `EE_REG_CONFIG)
                   | (i_paddr == `EE_REG_PEEK_ADDR) | (i_paddr == `EE_REG_PEEK_DATA);

  // One wait state: answer registered in the first access cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
      guard_en_q <= `EE_CFG_GUARD_RST;
      peek_q <= 11'h000;
    end else begin
      o_pready <= apb_acc;
      o_pslverr <= apb_acc & ~apb_hit;
      o_prdata <= 32'h0000_0000;
      if (apb_acc && i_pwrite) begin
        if (i_paddr == `EE_REG_CONFIG) begin
          guard_en_q <= i_pwdata[0];
        end
        if (i_paddr == `EE_REG_PEEK_ADDR) begin
          peek_q <= i_pwdata[10:0];
        end
      end else if (apb_acc) begin
        case (i_paddr)
          `EE_REG_STATUS: o_prdata <= {21'd0, cs_n & ~busy_q, paused_q, ~cs_n, status};
          `EE_REG_CONFIG: o_prdata <= {31'd0, guard_en_q};
          `EE_REG_PEEK_ADDR: o_prdata <= {21'd0, peek_q};
          `EE_REG_PEEK_DATA: o_prdata <= {24'd0, mem_q[peek_q]};
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_so_deselect: assert property (@(posedge i_clk) disable iff (i_srst)
    cs_n |=> !o_so_oe) else $error("Data out driven while deselected");
  a_hold_release: assert property (@(posedge i_clk) disable iff (i_srst)
    !hold_n |=> !o_so_oe) else $error("Data out driven with pause low");
  a_pause_freeze: assert property (@(posedge i_clk) disable iff (i_srst)
    paused_q && !cs_n |=> $stable(st_q) && $stable(cnt_q))
    else $error("Sequence moved while paused");
  a_prog_runs: assert property (@(posedge i_clk) disable iff (i_srst)
    busy_q && tmr_q > 20'd1 |=> busy_q && tmr_q == $past(tmr_q) - 20'd1)
    else $error("Programming cut short");
  a_write_start: assert property (@(posedge i_clk) disable iff (i_srst)
    write_go |=> busy_q && tmr_q == TWC && !stat_kind_q)
    else $error("Valid write did not start programming");
  a_latch_cause: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(latch_q) |-> $past(cs_rise) && $past(op_q) == `EE_OP_LATCH_SET)
    else $error("Latch set without full opcode");
  a_latch_done: assert property (@(posedge i_clk) disable iff (i_srst)
    prog_done && !latch_set |=> !latch_q) else $error("Latch kept after programming");
  a_wp_refuse: assert property (@(posedge i_clk) disable iff (i_srst)
    cs_rise && st_q == ST_ARMED && op_q == `EE_OP_STAT_WR && pen_q && !wp_n && !busy_q
    |=> !busy_q) else $error("Protected status write started");
  a_read_blocked: assert property (@(posedge i_clk) disable iff (i_srst)
    addr_end && busy_q |=> st_q == ST_IGNORE) else $error("Array read during programming");
  a_addr_wrap: assert property (@(posedge i_clk) disable iff (i_srst)
    byte_end && st_q == ST_RDATA && addr_q == 11'h7FF |=> addr_q == 11'h000)
    else $error("Read address did not wrap");
  a_first_select: assert property (@(posedge i_clk) disable iff (i_srst)
    cs_fall && !seen_low_q |=> st_q == ST_IDLE) else $error("Sequence before first select");

endmodule

// ### verification/spi_master_model.sv
/*
  SPI master model for the serial EEPROM port: drives select, clock, data
  and pause in mode 0 and reads the resolved data-out wire.
  Assumes the bench calls its tasks and feeds it the resolved wire.
*/
`timescale 1ns/10ps

module spi_master_model (
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  output logic o_hold_n,
  input wire logic i_so
);
  // Idle: deselected, clock parked low, pause released
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
    o_hold_n = 1'b1;
  end

  // Select with margin before the first clock rise
  task start();
    o_cs_n = 1'b0;
    #60;
  endtask

  // Deselect with the clock low, 30 ns after the last bit
  task stop();
    #30 o_cs_n = 1'b1;
    #100;
  endtask

  // Shift nb bits MSB first; output read late in the high phase since the
  // port updates it several of its clocks after each fall
  task xb(input logic [7:0] t, input int nb, output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      o_si = t[i];
      #24 o_sck = 1'b1;
      #23 r = {r[6:0], i_so};
      #1 o_sck = 1'b0;
    end
  endtask

  // Pause pin moves only while the clock is parked low
  task hold(input logic v);
    #10 o_hold_n = v;
    #60;
  endtask
endmodule

// ### verification/spi_serial_eeprom_port_tb_top.sv
/*
  Self-checking bench of the serial EEPROM port: SPI master model on the
  link, APB tasks on the register side, behavioural array and status model.
  Assumes the rtl files and the master model are compiled first.
*/
`timescale 1ns/10ps
`include "spi_eeprom_map.svh"

module spi_serial_eeprom_port_tb_top;
  localparam int WC = 2000;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wp_n = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, so, so_oe, cs_n, sck, si, hold_n;
  logic so_last = 1'b0;
  // Released wire flips every cycle so a stale value cannot pass
  wire so_w = so_oe ? so : ~so_last;
  logic [31:0] seed = 32'hd28d_d499;
  logic [7:0] mem [0:2047];
  logic [7:0] st_m = 8'h00;
  logic [7:0] q [$];
  logic [7:0] r;
  logic [31:0] rd;
  logic [10:0] pa;
  logic e;
  int err_count = 0;
  int n_tests = 0;
  int oe_n = 0;
  int base;

  always #2.5 clk = ~clk;
  always @(posedge clk) so_last <= (so_w === 1'b1);
  // Cycles with data-out driven, to prove refused frames stay silent
  always @(posedge clk) if (so_oe === 1'b1) oe_n <= oe_n + 1;

  spi_eeprom_port #(.WRITE_CYCLES(WC)) spi_eeprom_port_i (.i_clk(clk), .i_srst(srst),
    .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n),
    .o_so(so), .o_so_oe(so_oe), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr));
  spi_master_model spi_master_model_i (.o_cs_n(cs_n), .o_sck(sck), .o_si(si),
    .o_hold_n(hold_n), .i_so(so_w));

  // ****************************************
  // Helpers
  // ****************************************
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected APB status word: standby only when idle and deselected
  function logic [31:0] stw(input logic busy);
    return {21'h0, ~busy, 2'b00, st_m[7:1], busy};
  endfunction

  // One APB transfer; result left in rd and e
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No cycle count assumed: a slave that never answers is left to the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Poll until programming is over; a hang is left to the watchdog
  task idle();
    do begin
      apb(1'b0, `EE_REG_STATUS, 32'h0);
    end while (rd[0] !== 1'b0);
  endtask

  task sel();
    spi_master_model_i.start();
  endtask
  task rel();
    spi_master_model_i.stop();
  endtask
  task sx(input logic [7:0] t);
    spi_master_model_i.xb(t, 8, r);
  endtask

  task op1(input logic [7:0] op);
    sel();
    sx(op);
    rel();
  endtask
  task sread();
    sel();
    sx(`EE_OP_STAT_RD);
    sx(8'h00);
    rel();
  endtask
  task wen();
    op1(`EE_OP_LATCH_SET);
    st_m[1] = 1'b1;
  endtask

  // Page write of q, with pb stray bits after it; model follows the rules
  task wr(input logic [15:0] a, input int pb);
    sel();
    sx(`EE_OP_WRITE);
    sx(a[15:8]);
    sx(a[7:0]);
    foreach (q[i]) sx(q[i]);
    spi_master_model_i.xb(8'h55, pb, r);
    rel();
    if (st_m[1] && pb == 0) begin
      foreach (q[i]) mem[{a[10:4], 4'(a[3:0] + i)}] = q[i];
      st_m[1] = 1'b0;
    end
  endtask

  // Status write; refused ones leave the latch as it was; drop lowers the
  // protect pin once programming has started, which must not stop it
  task swr(input logic [7:0] d, input logic drop);
    wen();
    sel();
    sx(`EE_OP_STAT_WR);
    sx(d);
    rel();
    if (!(st_m[7] && !wp_n)) begin
      st_m = {d[7], 3'b000, d[3:2], 2'b00};
    end
    if (drop) begin
      @(posedge clk) wp_n <= 1'b0;
    end
    idle();
    sread();
    chk(r, st_m);
  endtask

  // Sequential read of n bytes with a pause, clocked meanwhile, before byte hb
  task rdn(input logic [15:0] a, input int n, input int hb);
    sel();
    sx(`EE_OP_READ);
    sx(a[15:8]);
    sx(a[7:0]);
    for (int i = 0; i < n; i++) begin
      if (i == hb) begin
        spi_master_model_i.hold(1'b0);
        chk(so_oe, 1'b0);
        // Still selected while paused, and not in standby
        apb(1'b0, `EE_REG_STATUS, 32'h0);
        chk(rd, {21'h0, 3'b011, st_m});
        sx(8'hff);
        spi_master_model_i.hold(1'b1);
      end
      sx(8'h00);
      chk(r, mem[11'(a + i)]);
    end
    rel();
    chk(so_oe, 1'b0);
  endtask

  task results();
    $display("errors %0d tests %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs about a quarter of this
  initial begin
    #400000;
    chk(32'h0, 32'h1);
    results();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, `EE_REG_STATUS, 32'h0);
    chk(rd, stw(1'b0));
    apb(1'b1, `EE_REG_CONFIG, 32'h0);
    apb(1'b0, `EE_REG_CONFIG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `EE_REG_CONFIG, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], e}, 32'h1);
    // First select only arms the link
    op1(`EE_OP_LATCH_SET);
    sread();
    chk(r, st_m);
    wen();
    sread();
    chk(r, st_m);
    op1(`EE_OP_LATCH_CLR);
    st_m[1] = 1'b0;
    sread();
    chk(r, st_m);
    // Latch set followed by more bits in the same select does nothing
    sel();
    sx(`EE_OP_LATCH_SET);
    sx(`EE_OP_WRITE);
    rel();
    sread();
    chk(r, st_m);
    base = oe_n;
    sel();
    sx(8'hff);
    sx(8'h00);
    rel();
    chk(oe_n, base);
    q = {8'h3c};
    wr(16'h0123, 0);
    apb(1'b0, `EE_REG_STATUS, 32'h0);
    chk(rd, stw(1'b0));
    // Protect pin against the enable bit
    @(posedge clk) wp_n <= 1'b0;
    swr(8'h80, 1'b0);
    swr(8'h8c, 1'b0);
    // Fill the top and bottom pages for the wrap read
    for (int p = 0; p < 2; p++) begin
      q.delete();
      repeat (16) q.push_back(8'(xs()));
      wen();
      rd = xs();
      wr({rd[15:11], p ? 11'h7f0 : 11'h000}, 0);
      idle();
    end
    // Page write of 18 bytes from offset 14 wraps inside the page
    q.delete();
    repeat (18) q.push_back(8'(xs()));
    wen();
    rd = xs();
    pa = rd[10:0];
    wr({rd[15:4], 4'he}, 0);
    @(posedge clk) wp_n <= 1'b0;
    apb(1'b0, `EE_REG_STATUS, 32'h0);
    chk(rd, stw(1'b1) | 32'h2);
    base = oe_n;
    sel();
    sx(`EE_OP_READ);
    sx(8'h00);
    sx(8'h00);
    sx(8'h00);
    rel();
    chk(oe_n, base);
    sread();
    chk(r, st_m | 8'h03);
    idle();
    @(posedge clk) wp_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, `EE_REG_PEEK_ADDR, {21'h0, pa[10:4], 4'(i)});
      apb(1'b0, `EE_REG_PEEK_DATA, 32'h0);
      chk(rd, mem[{pa[10:4], 4'(i)}]);
    end
    sread();
    chk(r, st_m);
    swr(8'h00, 1'b1);
    // Select raised three bits into a byte abandons the write
    wen();
    q = {8'h5a};
    wr(16'hf100, 3);
    apb(1'b0, `EE_REG_STATUS, 32'h0);
    chk(rd, stw(1'b0));
    op1(`EE_OP_LATCH_CLR);
    st_m[1] = 1'b0;
    rd = xs();
    rdn({rd[15:11], 11'h7fc}, 8, 3);
    results();
  end
endmodule
